// File: hw/xmp_map.svh
// Register map, field positions, reset values and region decode constants
`ifndef XMP_MAP_SVH
`define XMP_MAP_SVH

`define XMP_GLOBAL_OFS 32'hFFFFF000
`define XMP_CTRL0_OFS 32'hFFFFF010
`define XMP_CTRL1_OFS 32'hFFFFF014
`define XMP_CTRL2_OFS 32'hFFFFF018
`define XMP_CTRL3_OFS 32'hFFFFF01C
`define XMP_TIMING0_OFS 32'hFFFFF020
`define XMP_TIMING1_OFS 32'hFFFFF024
`define XMP_TIMING2_OFS 32'hFFFFF028
`define XMP_TIMING3_OFS 32'hFFFFF02C

`define XMP_GLOBAL_RESET 8'h00
`define XMP_CTRL_RESET 8'h00
`define XMP_TIMING_RESET 16'h70FF
`define XMP_TIMING_MASK 16'hF7FF

`define XMP_GLOBAL_ON_BIT 0
`define XMP_CTRL_ENABLE_BIT 0
`define XMP_CTRL_WIDE_BIT 1
`define XMP_TIM_BYTE_GATE_BIT 15
`define XMP_TIM_LATCH_HI 14
`define XMP_TIM_LATCH_LO 12
`define XMP_TIM_NO_HOLD_BIT 10
`define XMP_TIM_NO_RD_TURN_BIT 9
`define XMP_TIM_NO_WR_TURN_BIT 8
`define XMP_TIM_WR_LEN_HI 7
`define XMP_TIM_WR_LEN_LO 4
`define XMP_TIM_RD_LEN_HI 3
`define XMP_TIM_RD_LEN_LO 0

`define XMP_REGION_TAG_HI 31
`define XMP_REGION_TAG_LO 16
`define XMP_REGION0_TAG 16'h1000
`define XMP_REGION1_TAG 16'h2000
`define XMP_REGION2_TAG 16'h3000
`define XMP_REGION3_TAG 16'h4000

`define XMP_IDX_NONE 4'hF
`define XMP_IDX_GLOBAL 4'h0
`define XMP_IDX_CTRL0 4'h1
`define XMP_IDX_TIMING0 4'h5

`endif

// File: hw/xmp_pkg.sv
// Types shared by the external memory port
package xmp_pkg;
    // Gray codes along IDLE, LATCH, HOLD, PRE, STROBE, POST, DONE
    typedef enum logic [2:0] {
        XMP_IDLE = 3'h0,
        XMP_LATCH = 3'h1,
        XMP_HOLD = 3'h3,
        XMP_PRE = 3'h2,
        XMP_STROBE = 3'h6,
        XMP_POST = 3'h7,
        XMP_DONE = 3'h5
    } xmp_state_t;

    typedef enum logic [1:0] {
        XMP_RESP_OKAY = 2'h0,
        XMP_RESP_SLVERR = 2'h2
    } xmp_resp_t;
endpackage

// File: hw/xmp_pin_sync.sv
// Two-stage synchroniser for the address/data bus input pins
`timescale 1ns/1ps
`default_nettype none
module xmp_pin_sync (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [15:0] pin_in, // Raw pin levels
    output logic [15:0] pin_sync // Synchronised levels
);
    logic [15:0] stage1;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1 <= 16'h0000;
            pin_sync <= 16'h0000;
        end else begin
            stage1 <= pin_in;
            pin_sync <= stage1;
        end
    end
endmodule // xmp_pin_sync
`default_nettype wire

// File: hw/xmp_region_decode.sv
// Region decode of a processor access address
`include "xmp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module xmp_region_decode (
    input wire logic [31:0] addr, // Processor access address
    output logic hit, // Address falls in one of four regions
    output logic [1:0] region // Region number when hit
);
    logic [15:0] tag;

    assign tag = addr[`XMP_REGION_TAG_HI:`XMP_REGION_TAG_LO];

    always_comb begin
        hit = 1'b1;
        region = 2'h0;
        if (tag == `XMP_REGION0_TAG) begin
            region = 2'h0;
        end else if (tag == `XMP_REGION1_TAG) begin
            region = 2'h1;
        end else if (tag == `XMP_REGION2_TAG) begin
            region = 2'h2;
        end else if (tag == `XMP_REGION3_TAG) begin
            region = 2'h3;
        end else begin
            hit = 1'b0;
        end
    end
endmodule // xmp_region_decode
`default_nettype wire

// File: hw/xmp_port.sv
// External asynchronous memory port: AXI4-Lite registers and pin sequencer
// Behaviour
// - Only the low sixteen address bits reach the pins; upper bits decode.
// - Four regions at 0x1..0x4 followed by zeros, each 64 K, own select.
// - Regions up to 128 kB; 8-bit memory gets an extra upper address line. Here the decode covers 64 K only, so that line stays low.
// - Control bit 0 enables the region.
// - Control bit 1 selects a 16-bit bus, clear gives 8-bit.
// - Timing bit 15 gates lowest address bit with write strobe; else byte lanes.
// - Timing bits 14:12 add wait states to the latch strobe.
// - Timing bit 10 clear adds one address hold cycle.
// - Timing bit 9 clear adds turnaround before and after read strobe.
// - Timing bit 8 clear adds turnaround before and after write strobe.
// - Timing bits 7:4 give write strobe length, code plus one clocks.
// - Timing bits 3:0 give read strobe length, code plus one clocks.
//
// Chosen here: the AXI4-Lite register port.
`include "xmp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module xmp_port
    import xmp_pkg::*;
(
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic rst_n, // Synchronous reset, active low
    // AXI4-Lite register slave
    input wire logic [31:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    // Processor access port
    input wire logic mem_req, // Access request, held until mem_ack
    input wire logic [31:0] mem_addr, // Byte address of the access
    input wire logic mem_we, // One for write
    input wire logic [15:0] mem_wdata, // Write data
    input wire logic [1:0] mem_be, // Byte enables, 16-bit regions
    output logic mem_ack, // One-cycle completion pulse
    output logic mem_err, // Refused access, with mem_ack
    output logic [15:0] mem_rdata, // Read data, valid with mem_ack
    // External memory pins
    output logic [15:0] ad_out, // Address/data bus drive value
    output logic ad_oe, // Address/data bus drive enable
    input wire logic [15:0] ad_in, // Address/data bus pin level
    output logic upper_extra_address_bit, // Extra address line, 8-bit regions
    output logic lowest_address_bit, // Lowest address bit, optionally gated
    output logic [3:0] region_select_n, // Region selects, active low
    output logic write_strobe_n, // Write strobe, active low
    output logic read_strobe_n, // Read strobe, active low
    output logic latch_strobe, // Address latch strobe, active high
    output logic high_byte_lane_select, // High byte lane, active high
    output logic low_byte_lane_select // Low byte lane, active high
);
    logic [7:0] global_reg;
    logic [7:0] ctrl_reg [4];
    logic [15:0] timing_reg [4];

    logic aw_held;
    logic [31:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    xmp_state_t state;
    xmp_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    logic [1:0] acc_region;
    logic [16:0] acc_addr;
    logic acc_we;
    logic [15:0] acc_wdata;
    logic [1:0] acc_be;

    logic dec_hit;
    logic [1:0] dec_region;
    logic [15:0] ad_sync;
    logic req_ok;
    logic take_req;

    // Register index of a byte address, or none
    function automatic logic [3:0] reg_index(input logic [31:0] a);
        logic [3:0] idx;
        idx = `XMP_IDX_NONE;
        if (a == `XMP_GLOBAL_OFS) begin
            idx = `XMP_IDX_GLOBAL;
        end else if (a == `XMP_CTRL0_OFS) begin
            idx = 4'h1;
        end else if (a == `XMP_CTRL1_OFS) begin
            idx = 4'h2;
        end else if (a == `XMP_CTRL2_OFS) begin
            idx = 4'h3;
        end else if (a == `XMP_CTRL3_OFS) begin
            idx = 4'h4;
        end else if (a == `XMP_TIMING0_OFS) begin
            idx = 4'h5;
        end else if (a == `XMP_TIMING1_OFS) begin
            idx = 4'h6;
        end else if (a == `XMP_TIMING2_OFS) begin
            idx = 4'h7;
        end else if (a == `XMP_TIMING3_OFS) begin
            idx = 4'h8;
        end
        return idx;
    endfunction

    // Merge write data into a 16-bit value under byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] v;
        v = old;
        if (s[0]) begin
            v[7:0] = d[7:0];
        end
        if (s[1]) begin
            v[15:8] = d[15:8];
        end
        return v;
    endfunction

    xmp_region_decode u_decode (
        .addr(mem_addr),
        .hit(dec_hit),
        .region(dec_region)
    );

    xmp_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(ad_in),
        .pin_sync(ad_sync)
    );

    // AXI write channels, taken in either order
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h00000000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= XMP_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (!aw_held && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= s_axi_awvalid;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (!w_held && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= s_axi_wvalid;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (reg_index(aw_addr) == `XMP_IDX_NONE) ? XMP_RESP_SLVERR : XMP_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [3:0] idx;
    logic [3:0] ridx;
    assign idx = reg_index(aw_addr);
    assign ridx = reg_index(s_axi_araddr);

    // Register storage; writes are not blocked by a running access
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            global_reg <= `XMP_GLOBAL_RESET;
            for (int i = 0; i < 4; i++) begin
                ctrl_reg[i] <= `XMP_CTRL_RESET;
                timing_reg[i] <= `XMP_TIMING_RESET;
            end
        end else if (aw_held && w_held && !s_axi_bvalid && w_strb[0]) begin
            if (idx == `XMP_IDX_GLOBAL) begin
                global_reg <= w_data[7:0];
            end else if (idx >= `XMP_IDX_CTRL0 && idx < `XMP_IDX_TIMING0) begin
                ctrl_reg[2'(idx - `XMP_IDX_CTRL0)] <= w_data[7:0];
            end else if (idx != `XMP_IDX_NONE) begin
                timing_reg[2'(idx - `XMP_IDX_TIMING0)] <=
                    merge16(timing_reg[2'(idx - `XMP_IDX_TIMING0)], w_data, w_strb) & `XMP_TIMING_MASK;
            end
        end else if (aw_held && w_held && !s_axi_bvalid && w_strb[1] && idx >= `XMP_IDX_TIMING0 &&
                     idx != `XMP_IDX_NONE) begin
            timing_reg[2'(idx - `XMP_IDX_TIMING0)] <=
                merge16(timing_reg[2'(idx - `XMP_IDX_TIMING0)], w_data, w_strb) & `XMP_TIMING_MASK;
        end
    end

    // AXI read channel, answer one cycle after the address
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= XMP_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= XMP_RESP_OKAY;
                if (ridx == `XMP_IDX_GLOBAL) begin
                    s_axi_rdata <= {24'h000000, global_reg};
                end else if (ridx >= `XMP_IDX_CTRL0 && ridx < `XMP_IDX_TIMING0) begin
                    s_axi_rdata <= {24'h000000, ctrl_reg[2'(ridx - `XMP_IDX_CTRL0)]};
                end else if (ridx != `XMP_IDX_NONE) begin
                    s_axi_rdata <= {16'h0000, timing_reg[2'(ridx - `XMP_IDX_TIMING0)]};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= XMP_RESP_SLVERR;
                end
            end else begin
                s_axi_arready <= s_axi_arvalid;
            end
        end
    end

    // no new access is taken while global enable is off
    assign req_ok = dec_hit && global_reg[`XMP_GLOBAL_ON_BIT] &&
                    ctrl_reg[dec_region][`XMP_CTRL_ENABLE_BIT];
    // Guard on mem_ack keeps a still-held request from being taken twice
    assign take_req = (state == XMP_IDLE) && mem_req && !mem_ack;

    // Pins need the new access in the take cycle, before the capture registers load
    logic [1:0] pin_region;
    logic [16:0] pin_addr;
    logic [1:0] pin_be;
    assign pin_region = (state == XMP_IDLE) ? dec_region : acc_region;
    assign pin_addr = (state != XMP_IDLE) ? acc_addr :
                      ctrl_reg[dec_region][`XMP_CTRL_WIDE_BIT] ? {1'b0, mem_addr[16:1]} : mem_addr[16:0];
    assign pin_be = (state == XMP_IDLE) ? mem_be : acc_be;

    // Timing fields of the region under access
    logic [15:0] tim;
    logic wide;
    logic turn;
    logic [3:0] strobe_len;
    assign tim = timing_reg[pin_region];
    assign wide = ctrl_reg[pin_region][`XMP_CTRL_WIDE_BIT];
    assign turn = acc_we ? !tim[`XMP_TIM_NO_WR_TURN_BIT] : !tim[`XMP_TIM_NO_RD_TURN_BIT];
    assign strobe_len = acc_we ? tim[`XMP_TIM_WR_LEN_HI:`XMP_TIM_WR_LEN_LO] :
                                 tim[`XMP_TIM_RD_LEN_HI:`XMP_TIM_RD_LEN_LO];

    always_comb begin
        next_state = state;
        next_cnt = (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
        case (state)
            XMP_IDLE: begin
                if (take_req && req_ok) begin
                    next_state = XMP_LATCH;
                    next_cnt = {1'b0, timing_reg[dec_region][`XMP_TIM_LATCH_HI:`XMP_TIM_LATCH_LO]};
                end
            end
            XMP_LATCH: begin
                if (cnt == 4'h0) begin
                    if (!tim[`XMP_TIM_NO_HOLD_BIT]) begin
                        next_state = XMP_HOLD;
                    end else if (turn) begin
                        next_state = XMP_PRE;
                    end else begin
                        next_state = XMP_STROBE;
                        next_cnt = strobe_len;
                    end
                end
            end
            XMP_HOLD: begin
                if (turn) begin
                    next_state = XMP_PRE;
                end else begin
                    next_state = XMP_STROBE;
                    next_cnt = strobe_len;
                end
            end
            XMP_PRE: begin
                next_state = XMP_STROBE;
                next_cnt = strobe_len;
            end
            XMP_STROBE: begin
                if (cnt == 4'h0) begin
                    next_state = turn ? XMP_POST : XMP_DONE;
                end
            end
            XMP_POST: begin
                next_state = XMP_DONE;
            end
            XMP_DONE: begin
                next_state = XMP_IDLE;
            end
            default: begin
                next_state = XMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= XMP_IDLE;
            cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Capture of the access when taken
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_region <= 2'h0;
            acc_addr <= 17'h00000;
            acc_we <= 1'b0;
            acc_wdata <= 16'h0000;
            acc_be <= 2'h0;
        end else if (take_req && req_ok) begin
            acc_region <= dec_region;
            acc_we <= mem_we;
            acc_wdata <= mem_wdata;
            acc_be <= mem_be;
            acc_addr <= pin_addr;
        end
    end

    // Processor answer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= 16'h0000;
        end else begin
            mem_ack <= (next_state == XMP_DONE) || (take_req && !req_ok);
            mem_err <= take_req && !req_ok;
            // Pin data lags two cycles through the synchroniser
            if (state == XMP_STROBE && cnt == 4'h0 && !acc_we) begin
                if (wide) begin
                    mem_rdata <= ad_sync;
                end else begin
                    mem_rdata <= {ad_sync[7:0], ad_sync[7:0]};
                end
            end
        end
    end

    // Pin outputs, registered from the next state
    logic nx_active;
    logic nx_addr_phase;
    logic nx_strobe;
    assign nx_active = (next_state != XMP_IDLE) && (next_state != XMP_DONE);
    assign nx_addr_phase = (next_state == XMP_LATCH) || (next_state == XMP_HOLD);
    assign nx_strobe = (next_state == XMP_STROBE);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ad_out <= 16'h0000;
            ad_oe <= 1'b0;
            upper_extra_address_bit <= 1'b0;
            latch_strobe <= 1'b0;
            region_select_n <= 4'hF;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else begin
            // latch strobe with address on the bus
            latch_strobe <= (next_state == XMP_LATCH);
            region_select_n <= nx_active ? ~(4'h1 << pin_region) : 4'hF;
            read_strobe_n <= !(nx_strobe && !acc_we);
            write_strobe_n <= !(nx_strobe && acc_we);
            // Bus released for reads outside the address phase
            ad_oe <= nx_addr_phase || (nx_active && acc_we);
            // extra line only for 8-bit regions
            upper_extra_address_bit <= nx_active && !wide && pin_addr[16];
            if (nx_addr_phase) begin
                ad_out <= pin_addr[15:0];
            end else if (wide) begin
                ad_out <= acc_wdata;
            end else begin
                ad_out <= {8'h00, acc_addr[0] ? acc_wdata[15:8] : acc_wdata[7:0]};
            end
        end
    end

    // byte write gating or byte lanes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lowest_address_bit <= 1'b0;
            high_byte_lane_select <= 1'b0;
            low_byte_lane_select <= 1'b0;
        end else if (!nx_active) begin
            lowest_address_bit <= 1'b0;
            high_byte_lane_select <= 1'b0;
            low_byte_lane_select <= 1'b0;
        end else if (tim[`XMP_TIM_BYTE_GATE_BIT]) begin
            // Low only while writing the even byte; a second chip needs its own decode
            lowest_address_bit <= pin_addr[0] || !(nx_strobe && acc_we);
            high_byte_lane_select <= 1'b1;
            low_byte_lane_select <= 1'b1;
        end else begin
            lowest_address_bit <= pin_addr[0];
            high_byte_lane_select <= wide ? pin_be[1] : pin_addr[0];
            low_byte_lane_select <= wide ? pin_be[0] : !pin_addr[0];
        end
    end
endmodule // xmp_port
`default_nettype wire

// File: tb/xmp_port_props.sv
// Pin-level assertion checker for the external memory port
`timescale 1ns/1ps
`default_nettype none
module xmp_port_props (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset
    input wire logic mem_ack, // Done
    input wire logic mem_err, // Refused
    input wire logic ad_oe, // Bus drive
    input wire logic [3:0] region_select_n, // Selects
    input wire logic write_strobe_n, // Write strobe
    input wire logic read_strobe_n, // Read strobe
    input wire logic latch_strobe // Latch strobe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_rd_start; $fell(read_strobe_n); endsequence
    sequence s_done; mem_ack && !mem_err; endsequence
    property p_sel_one; $onehot0(~region_select_n); endproperty
    property p_strobe_excl; read_strobe_n || write_strobe_n; endproperty
    property p_err_quiet; mem_err |-> mem_ack && region_select_n == 4'hF && read_strobe_n && write_strobe_n; endproperty
    property p_rd_float; s_rd_start |-> !ad_oe && !latch_strobe; endproperty
    property p_wr_drive; !write_strobe_n |-> ad_oe && !latch_strobe; endproperty
    property p_strobe_sel; !(read_strobe_n && write_strobe_n) |-> region_select_n != 4'hF; endproperty
    property p_ack_after; s_done |-> $past(region_select_n) != 4'hF && region_select_n == 4'hF; endproperty
    property p_latch_sel; $rose(latch_strobe) |-> region_select_n != 4'hF && ad_oe; endproperty
    a_sel_one: assert property (p_sel_one) else $error("two selects low");
    a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");
    a_err_quiet: assert property (p_err_quiet) else $error("refused access moved pins");
    a_rd_float: assert property (p_rd_float) else $error("bus driven at read strobe");
    a_wr_drive: assert property (p_wr_drive) else $error("bus not driven at write strobe");
    a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
    a_ack_after: assert property (p_ack_after) else $error("ack without select phase");
    a_latch_sel: assert property (p_latch_sel) else $error("latch without address drive");
endmodule // xmp_port_props
bind xmp_port xmp_port_props i_props (.*);
`default_nettype wire

// File: tb/xmp_mem_model.sv
// Behavioural asynchronous 16-bit memory on the port pins
`timescale 1ns/1ps
`default_nettype none
module xmp_mem_model (
    input wire logic clk_sys, // Clock
    input wire logic [15:0] ad_out, // Bus drive value
    input wire logic latch_strobe, // Address latch
    input wire logic write_strobe_n, // Write strobe
    input wire logic read_strobe_n, // Read strobe
    input wire logic [3:0] region_select_n, // Selects
    output logic [15:0] ad_in // Bus level
);
    logic [15:0] mem [0:255];
    logic [7:0] addr = 8'h00;
    always_ff @(posedge clk_sys) begin
        if (latch_strobe) addr <= ad_out[7:0];
        if (!write_strobe_n && region_select_n != 4'hF) mem[addr] <= ad_out;
    end
    // Released bus shows inverted data, never a stale match
    assign ad_in = (!read_strobe_n && region_select_n != 4'hF) ? mem[addr] : ~mem[addr];
endmodule // xmp_mem_model
`default_nettype wire

// File: tb/tb_external_async_memory_port.sv
// Self-checking bench for the external memory port
`include "xmp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_external_async_memory_port;
    logic clk_sys = 1'b0, rst_n = 1'b0, mem_req = 1'b0, mem_we = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, mem_addr = '0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_ack, mem_err, ad_oe;
    logic write_strobe_n, read_strobe_n, latch_strobe;
    logic [15:0] mem_wdata = '0, ad_in, ad_out, mem_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] region_select_n;
    int num_errors = 0, checks_done = 0, cyc = 0;
    xmp_port i_dut (.*, .s_axi_wstrb(4'hF), .mem_be(2'h3), .upper_extra_address_bit(), .lowest_address_bit(),
        .high_byte_lane_select(), .low_byte_lane_select());
    xmp_mem_model i_mem (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        // Late ready makes the slave hold its answer
        @(posedge clk_sys);
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic mem_acc(input logic [31:0] a, input logic we, input logic [15:0] wd,
                           output logic [15:0] rd, output logic err, output int n, output int sl);
        @(posedge clk_sys);
        mem_addr <= a;
        mem_we <= we;
        mem_wdata <= wd;
        mem_req <= 1'b1;
        n = 0;
        sl = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (!read_strobe_n || !write_strobe_n) sl++;
        end while (mem_ack !== 1'b1);
        rd = mem_rdata;
        err = mem_err;
        @(posedge clk_sys);
        mem_req <= 1'b0;
    endtask
    // Negedges from request to ack: latch, hold, two turnarounds, strobe, done
    function automatic int exp_cyc(input logic [15:0] t, input logic we);
        int s, tt;
        s = we ? int'(t[7:4]) : int'(t[3:0]);
        tt = we ? int'(!t[8]) : int'(!t[9]);
        return 4 + int'(t[14:12]) + int'(!t[10]) + 2 * tt + s;
    endfunction
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(`XMP_GLOBAL_OFS, d, r);
        chk(d, 32'h0);
        axi_rd(`XMP_CTRL2_OFS, d, r);
        chk(d, 32'h0);
        axi_rd(`XMP_TIMING1_OFS, d, r);
        chk(d, 32'h70FF);
        axi_wr(`XMP_TIMING3_OFS, 32'hFFFF);
        axi_rd(`XMP_TIMING3_OFS, d, r);
        chk(d, 32'hF7FF);
        axi_rd(32'hFFFFF004, d, r);
        chk({30'h0, r}, 32'h2);
    endtask
    task automatic t_refused;
        logic [15:0] rd;
        logic e;
        int n, sl;
        mem_acc(32'h10000004, 1'b1, 16'h1234, rd, e, n, sl);
        chk({31'h0, e}, 32'h1);
        chk(sl, 0);
        axi_wr(`XMP_GLOBAL_OFS, 32'h1);
        axi_wr(`XMP_CTRL1_OFS, 32'h2);
        mem_acc(32'h20000004, 1'b0, 16'h0, rd, e, n, sl);
        chk({31'h0, e}, 32'h1);
        chk(sl, 0);
    endtask
    task automatic t_timing(input logic [15:0] t, input logic [15:0] v);
        logic [15:0] rd;
        logic e;
        int n, sl;
        axi_wr(`XMP_CTRL0_OFS, 32'h3);
        axi_wr(`XMP_TIMING0_OFS, {16'h0, t});
        mem_acc(32'h10000010, 1'b1, v, rd, e, n, sl);
        chk(n, exp_cyc(t, 1'b1));
        chk(sl, int'(t[7:4]) + 1);
        mem_acc(32'h10000010, 1'b0, 16'h0, rd, e, n, sl);
        chk(n, exp_cyc(t, 1'b0));
        chk(sl, int'(t[3:0]) + 1);
        chk({15'h0, e, rd}, {16'h0, v});
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            test_done;
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs;
        t_refused;
        t_timing(16'h0712, 16'hA55A);
        t_timing(16'h3053, 16'h5AA5);
        t_timing(16'h70FF, 16'h0FF0);
        test_done;
    end
endmodule // tb_external_async_memory_port
`default_nettype wire
